// File: hw/charger_input_supervisor.sv
// Charger input supervisor: limit selection, OVP/UVLO qualification, power path, events.
// Assumes sampled supply voltages in mV from converters on other clocks, mode pins from
// the board, and an APB master on core_clk.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "charger_input_supervisor_cfg.svh"

module charger_input_supervisor (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [13:0] supply_mv,
    input  wire logic [13:0] adapter_pin_mv,
    input  wire logic [13:0] system_rail_mv,
    input  wire logic [13:0] system_rail_target_mv,
    input  wire logic        charge_level_select,
    input  wire logic [11:0] charge_current_resistor_pin,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             input_valid,
    output logic             charge_enable,
    output logic             system_from_input,
    output logic             dynamic_charge_throttle,
    output logic      [11:0] input_current_limit_ma,
    output logic      [11:0] charge_current_ma,
    output logic             event_irq,
    output logic             irq_out_n
);
    // Synchronisers: three stages, a change counts when stages two and three agree
    logic [13:0] sup_s1, sup_s2, sup_s3, sup_q;
    logic [13:0] adp_s1, adp_s2, adp_s3, adp_q;
    logic [13:0] sys_s1, sys_s2, sys_s3, sys_q;
    logic        lvl_s1, lvl_s2, lvl_s3, lvl_q;

    always_ff @(posedge core_clk) begin
        sup_s1 <= supply_mv;
        sup_s2 <= sup_s1;
        sup_s3 <= sup_s2;
        adp_s1 <= adapter_pin_mv;
        adp_s2 <= adp_s1;
        adp_s3 <= adp_s2;
        sys_s1 <= system_rail_mv;
        sys_s2 <= sys_s1;
        sys_s3 <= sys_s2;
        lvl_s1 <= charge_level_select;
        lvl_s2 <= lvl_s1;
        lvl_s3 <= lvl_s2;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sup_q <= 14'h0000;
            adp_q <= 14'h0000;
            sys_q <= 14'h0000;
            lvl_q <= 1'b0;
        end else begin
            if (sup_s2 == sup_s3) sup_q <= sup_s3;
            if (adp_s2 == adp_s3) adp_q <= adp_s3;
            if (sys_s2 == sys_s3) sys_q <= sys_s3;
            if (lvl_s2 == lvl_s3) lvl_q <= lvl_s3;
        end
    end

    // Software registers
    logic [1:0] ovp_threshold_select_reg;
    logic       input_irq_enable_reg;
    logic       connect_irq_enable_reg;
    logic       disconnect_irq_enable_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] irq_stat_reg;
    logic       input_irq_flag_reg;
    logic       adapter_select_state;

    charger_input_supervisor_pkg::supply_state_type state_reg;
    logic [13:0] ovp_thresh;
    logic        in_ovp, in_uvlo, above_restart;
    logic        valid_prev_reg;

    always_comb begin
        unique case (ovp_threshold_select_reg)
            2'b00: ovp_thresh = `CIS_OVP_MV_0;
            2'b01: ovp_thresh = `CIS_OVP_MV_1;
            2'b10: ovp_thresh = `CIS_OVP_MV_2;
            2'b11: ovp_thresh = `CIS_OVP_MV_3;
        endcase
    end

    assign adapter_select_state = adp_q > `CIS_ADP_THRESH_MV;
    assign in_ovp        = sup_q > ovp_thresh;
    assign in_uvlo       = sup_q < `CIS_UVLO_MV;
    assign above_restart = sup_q >= (`CIS_UVLO_MV + `CIS_UVLO_HYST_MV);

    // Supply qualification with UVLO hysteresis and OVP resume level
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= charger_input_supervisor_pkg::SUPPLY_INVALID;
        end else begin
            unique case (state_reg)
                charger_input_supervisor_pkg::SUPPLY_INVALID: begin
                    if (in_ovp)
                        state_reg <= charger_input_supervisor_pkg::SUPPLY_OVP;
                    else if (above_restart)
                        state_reg <= charger_input_supervisor_pkg::SUPPLY_VALID;
                end
                charger_input_supervisor_pkg::SUPPLY_VALID: begin
                    if (in_ovp)
                        state_reg <= charger_input_supervisor_pkg::SUPPLY_OVP;
                    else if (in_uvlo)
                        state_reg <= charger_input_supervisor_pkg::SUPPLY_INVALID;
                end
                charger_input_supervisor_pkg::SUPPLY_OVP: begin
                    if (sup_q < `CIS_OVP_RESUME_MV)
                        state_reg <= charger_input_supervisor_pkg::SUPPLY_INVALID;
                end
                default: state_reg <= charger_input_supervisor_pkg::SUPPLY_INVALID;
            endcase
        end
    end

    logic valid_now;
    assign valid_now = state_reg == charger_input_supervisor_pkg::SUPPLY_VALID;

    logic connect_ev, disconnect_ev, ovp_ev, uvlo_ev;
    assign connect_ev    = valid_now && !valid_prev_reg;
    assign disconnect_ev = !valid_now && valid_prev_reg;
    assign ovp_ev        = (state_reg == charger_input_supervisor_pkg::SUPPLY_VALID) && in_ovp;
    assign uvlo_ev       = (state_reg == charger_input_supervisor_pkg::SUPPLY_VALID) && !in_ovp
                           && in_uvlo;

    // Power path, limits and throttle
    logic sag;
    assign sag = (system_rail_target_mv > sys_q)
                 && ((system_rail_target_mv - sys_q) > `CIS_SYS_SAG_MV);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            valid_prev_reg          <= 1'b0;
            input_valid             <= 1'b0;
            charge_enable           <= 1'b0;
            system_from_input       <= 1'b0;
            dynamic_charge_throttle <= 1'b0;
            input_current_limit_ma  <= `CIS_ILIM_USB_LO_MA;
            charge_current_ma       <= 12'h000;
        end else begin
            valid_prev_reg          <= valid_now;
            input_valid             <= valid_now;
            charge_enable           <= valid_now && !sag;
            system_from_input       <= valid_now;
            dynamic_charge_throttle <= valid_now && sag;
            if (adapter_select_state) begin
                input_current_limit_ma <= `CIS_ILIM_ADP_MA;
                charge_current_ma <= lvl_q ? charge_current_resistor_pin
                                   : charge_current_resistor_pin / `CIS_CHG_DIVIDE;
            end else begin
                input_current_limit_ma <= lvl_q ? `CIS_ILIM_USB_HI_MA
                                                : `CIS_ILIM_USB_LO_MA;
                charge_current_ma <= lvl_q ? `CIS_ILIM_USB_HI_MA
                                           : `CIS_ILIM_USB_LO_MA;
            end
        end
    end

    // APB slave: zero wait states
    logic setup_wr, access_rd, access_wr;
    assign access_wr = psel && penable && pwrite;
    assign access_rd = psel && penable && !pwrite;
    assign setup_wr  = access_wr;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ovp_threshold_select_reg  <= 2'b00;
            input_irq_enable_reg      <= 1'b0;
            connect_irq_enable_reg    <= 1'b0;
            disconnect_irq_enable_reg <= 1'b0;
            irq_mask_reg              <= 4'h0;
        end else if (setup_wr) begin
            if (paddr == `CIS_CTRL_ADDR) begin
                ovp_threshold_select_reg  <= pwdata[`CIS_CTRL_OVP_LSB +: 2];
                input_irq_enable_reg      <= pwdata[`CIS_CTRL_FLAG_EN];
                connect_irq_enable_reg    <= pwdata[`CIS_CTRL_CON_EN];
                disconnect_irq_enable_reg <= pwdata[`CIS_CTRL_DIS_EN];
            end
            if (paddr == `CIS_IRQ_MASK_ADDR)
                irq_mask_reg <= pwdata[3:0];
        end
    end

    // Input interrupt flag: set wins over the clearing read
    logic flag_set, flag_rd;
    assign flag_set = input_irq_enable_reg
                      && ((connect_ev && connect_irq_enable_reg)
                          || (disconnect_ev && disconnect_irq_enable_reg));
    assign flag_rd  = access_rd && (paddr == `CIS_STATUS_ADDR);

    always_ff @(posedge core_clk) begin
        if (sys_rst)
            input_irq_flag_reg <= 1'b0;
        else if (flag_set)
            input_irq_flag_reg <= 1'b1;
        else if (flag_rd)
            input_irq_flag_reg <= 1'b0;
    end

    // Sticky event status, write one to clear, set wins
    logic [3:0] ev_vec, w1c;
    assign ev_vec = {uvlo_ev, ovp_ev, disconnect_ev, connect_ev};
    assign w1c    = (access_wr && paddr == `CIS_IRQ_STAT_ADDR) ? pwdata[3:0] : 4'h0;

    always_ff @(posedge core_clk) begin
        if (sys_rst)
            irq_stat_reg <= 4'h0;
        else
            irq_stat_reg <= ev_vec | (irq_stat_reg & ~w1c);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_out_n <= 1'b1;
            event_irq <= 1'b0;
        end else begin
            irq_out_n <= !(input_irq_flag_reg || flag_set);
            event_irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `CIS_CTRL_ADDR: begin
                rd_mux[`CIS_CTRL_OVP_LSB +: 2] = ovp_threshold_select_reg;
                rd_mux[`CIS_CTRL_FLAG_EN]      = input_irq_enable_reg;
                rd_mux[`CIS_CTRL_CON_EN]       = connect_irq_enable_reg;
                rd_mux[`CIS_CTRL_DIS_EN]       = disconnect_irq_enable_reg;
            end
            `CIS_STATUS_ADDR: begin
                rd_mux[`CIS_ST_VALID]       = input_valid;
                rd_mux[`CIS_ST_ADAPTER]     = adapter_select_state;
                rd_mux[`CIS_ST_UVLO]        = in_uvlo;
                rd_mux[`CIS_ST_OVP]         = in_ovp;
                rd_mux[`CIS_ST_OVP_LATCH]   =
                    state_reg == charger_input_supervisor_pkg::SUPPLY_OVP;
                rd_mux[`CIS_ST_CHG_EN]      = charge_enable;
                rd_mux[`CIS_ST_SYS_FROM_IN] = system_from_input;
                rd_mux[`CIS_ST_THROTTLE]    = dynamic_charge_throttle;
                rd_mux[`CIS_ST_FLAG]        = input_irq_flag_reg;
            end
            `CIS_IRQ_STAT_ADDR: rd_mux[3:0] = irq_stat_reg;
            `CIS_IRQ_MASK_ADDR: rd_mux[3:0] = irq_mask_reg;
            `CIS_LIMITS_ADDR: begin
                rd_mux[11:0]  = input_current_limit_ma;
                rd_mux[27:16] = charge_current_ma;
            end
            `CIS_LEVELS_ADDR: rd_mux[13:0] = sup_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    logic addr_ok;
    assign addr_ok = (paddr == `CIS_CTRL_ADDR) || (paddr == `CIS_STATUS_ADDR)
                     || (paddr == `CIS_IRQ_STAT_ADDR) || (paddr == `CIS_IRQ_MASK_ADDR)
                     || (paddr == `CIS_LIMITS_ADDR) || (paddr == `CIS_LEVELS_ADDR);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (psel && !penable && !pwrite)
                prdata <= rd_mux;
        end
    end

    // Assertions
    property p_ovp_stops_charge;
        @(posedge core_clk) disable iff (sys_rst)
        (state_reg == charger_input_supervisor_pkg::SUPPLY_OVP) |=> !charge_enable;
    endproperty
    a_ovp_stops_charge: assert property (p_ovp_stops_charge)
        else $error("charging enabled during over-voltage");

    property p_ovp_resume;
        @(posedge core_clk) disable iff (sys_rst)
        (state_reg == charger_input_supervisor_pkg::SUPPLY_OVP && sup_q >= `CIS_OVP_RESUME_MV)
        |=> state_reg == charger_input_supervisor_pkg::SUPPLY_OVP;
    endproperty
    a_ovp_resume: assert property (p_ovp_resume)
        else $error("left over-voltage above resume level");

    property p_usb_limit;
        @(posedge core_clk) disable iff (sys_rst)
        (!adapter_select_state && $stable(lvl_q)) |=>
            input_current_limit_ma == ($past(lvl_q) ? `CIS_ILIM_USB_HI_MA : `CIS_ILIM_USB_LO_MA);
    endproperty
    a_usb_limit: assert property (p_usb_limit)
        else $error("wrong USB input limit");

    property p_adp_limit;
        @(posedge core_clk) disable iff (sys_rst)
        adapter_select_state |=> input_current_limit_ma == `CIS_ILIM_ADP_MA;
    endproperty
    a_adp_limit: assert property (p_adp_limit)
        else $error("wrong adapter input limit");

    property p_restart_level;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(valid_now) |-> $past(sup_q) >= (`CIS_UVLO_MV + `CIS_UVLO_HYST_MV);
    endproperty
    a_restart_level: assert property (p_restart_level)
        else $error("supply valid below restart level");

    property p_valid_path;
        @(posedge core_clk) disable iff (sys_rst)
        ##1 (system_from_input == input_valid);
    endproperty
    a_valid_path: assert property (p_valid_path)
        else $error("power path disagrees with input valid");

    property p_throttle;
        @(posedge core_clk) disable iff (sys_rst)
        dynamic_charge_throttle |-> !charge_enable;
    endproperty
    a_throttle: assert property (p_throttle)
        else $error("charging while throttled");

    sequence s_flag_event;
        flag_set;
    endsequence
    property p_irq_low;
        @(posedge core_clk) disable iff (sys_rst)
        s_flag_event |=> !irq_out_n && input_irq_flag_reg;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("interrupt not raised on input event");

    property p_flag_clear;
        @(posedge core_clk) disable iff (sys_rst)
        (flag_rd && !flag_set) |=> !input_irq_flag_reg ##1 irq_out_n;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag or interrupt not released after read");
endmodule
`default_nettype wire

// File: hw/charger_input_supervisor_cfg.svh
// Offsets, field positions, reset values, thresholds and limits of the charger input supervisor.
// Assumes inclusion by bare name; definitions only.
`ifndef CHARGER_INPUT_SUPERVISOR_CFG_SVH
`define CHARGER_INPUT_SUPERVISOR_CFG_SVH

// Register byte addresses
`define CIS_CTRL_ADDR       12'h000
`define CIS_STATUS_ADDR     12'h004
`define CIS_IRQ_STAT_ADDR   12'h008
`define CIS_IRQ_MASK_ADDR   12'h00c
`define CIS_LIMITS_ADDR     12'h010
`define CIS_LEVELS_ADDR     12'h014

// Control register fields
`define CIS_CTRL_OVP_LSB    0
`define CIS_CTRL_FLAG_EN    2
`define CIS_CTRL_CON_EN     3
`define CIS_CTRL_DIS_EN     4
`define CIS_CTRL_RESET      32'h0000_0000

// Status register fields
`define CIS_ST_VALID        0
`define CIS_ST_ADAPTER      1
`define CIS_ST_UVLO         2
`define CIS_ST_OVP          3
`define CIS_ST_OVP_LATCH    4
`define CIS_ST_CHG_EN       5
`define CIS_ST_SYS_FROM_IN  6
`define CIS_ST_THROTTLE     7
`define CIS_ST_FLAG         8

// Event status bits (write one to clear)
`define CIS_EV_CONNECT      0
`define CIS_EV_DISCONNECT   1
`define CIS_EV_OVP          2
`define CIS_EV_UVLO         3

// Thresholds in millivolts (14-bit ADC-style codes, 1 mV per LSB)
`define CIS_OVP_MV_0        14'd6600
`define CIS_OVP_MV_1        14'd7000
`define CIS_OVP_MV_2        14'd7500
`define CIS_OVP_MV_3        14'd8000
`define CIS_OVP_RESUME_MV   14'd6000
`define CIS_UVLO_MV         14'd3500
`define CIS_UVLO_HYST_MV    14'd500
`define CIS_SYS_SAG_MV      14'd200
`define CIS_ADP_THRESH_MV   14'd1200

// Input current limits in milliamps, and the adapter charge current divisor
`define CIS_ILIM_USB_LO_MA  12'd100
`define CIS_ILIM_USB_HI_MA  12'd450
`define CIS_ILIM_ADP_MA     12'd2000
`define CIS_CHG_DIVIDE      12'd5

`endif

// File: hw/charger_input_supervisor_pkg.sv
// Types shared by the charger input supervisor.
// Assumes nothing beyond a SystemVerilog compiler.
package charger_input_supervisor_pkg;
    typedef enum logic [1:0] {
        SUPPLY_INVALID = 2'b00,
        SUPPLY_VALID   = 2'b01,
        SUPPLY_OVP     = 2'b10
    } supply_state_type;
endpackage

// File: test/supply_partner.sv
// Far-side model: charger input supply, wall adapter divider and system rail.
// Assumes the bench sets targets; each level steps after a lag of core_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module supply_partner (
    input  wire logic        core_clk,
    input  wire logic [3:0]  lag,
    input  wire logic [13:0] supply_target,
    input  wire logic [13:0] adapter_target,
    input  wire logic [13:0] rail_target,
    output logic      [13:0] supply_mv,
    output logic      [13:0] adapter_pin_mv,
    output logic      [13:0] system_rail_mv
);
    logic [3:0] wait_reg = 4'h0;
    // A slow source holds its old level for lag cycles, then steps cleanly
    always @(posedge core_clk) begin
        if ({supply_target, adapter_target, rail_target} ==
            {supply_mv, adapter_pin_mv, system_rail_mv}) begin
            wait_reg <= 4'h0;
        end else if (wait_reg >= lag) begin
            supply_mv      <= supply_target;
            adapter_pin_mv <= adapter_target;
            system_rail_mv <= rail_target;
            wait_reg       <= 4'h0;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the charger input supervisor.
// Assumes the supply partner model and an APB master driven from here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [29:0] M_PWR  = 30'h3cffffff;
    localparam logic [29:0] M_IRQN = 30'h02000000;
    localparam logic [29:0] M_EVI  = 30'h01000000;
    typedef struct {string name; logic [32:0] mask; logic [32:0] exp;} note_type;
    note_type    notes[$];
    note_type    cur;
    logic [32:0] got;
    logic        core_clk = 1'b0, sys_rst = 1'b1, charge_level_select = 1'b0, smp = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, res = 12'd1000;
    logic [31:0] pwdata = 32'h0, seed = 32'h2b69;
    logic [3:0]  lag = 4'h0;
    logic [13:0] s_t = 14'd0, a_t = 14'd0, r_t = 14'd4200;
    logic [13:0] supply_mv, adapter_pin_mv, system_rail_mv;
    logic [31:0] prdata;
    logic        pready, pslverr, input_valid, charge_enable, system_from_input;
    logic        dynamic_charge_throttle, event_irq, irq_out_n;
    logic [11:0] input_current_limit_ma, charge_current_ma;
    logic [29:0] pv;
    logic [29:0] pw;
    logic [13:0] ovp_mv [4] = '{14'd6600, 14'd7000, 14'd7500, 14'd8000};
    int          n_errors = 0, cmp_count = 0;

    always #2 core_clk = ~core_clk;
    assign pv = {input_valid, charge_enable, system_from_input, dynamic_charge_throttle,
                 irq_out_n, event_irq, input_current_limit_ma, charge_current_ma};

    supply_partner partner (.core_clk(core_clk), .lag(lag), .supply_target(s_t),
        .adapter_target(a_t), .rail_target(r_t), .supply_mv(supply_mv),
        .adapter_pin_mv(adapter_pin_mv), .system_rail_mv(system_rail_mv));

    charger_input_supervisor dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .supply_mv(supply_mv), .adapter_pin_mv(adapter_pin_mv),
        .system_rail_mv(system_rail_mv), .system_rail_target_mv(14'd4200),
        .charge_level_select(charge_level_select), .charge_current_resistor_pin(res),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .input_valid(input_valid),
        .charge_enable(charge_enable), .system_from_input(system_from_input),
        .dynamic_charge_throttle(dynamic_charge_throttle),
        .input_current_limit_ma(input_current_limit_ma),
        .charge_current_ma(charge_current_ma), .event_irq(event_irq), .irq_out_n(irq_out_n));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected pin word from the present mode inputs
    function automatic logic [29:0] pexp(logic v, logic sag, logic irqn, logic evi);
        logic        ad;
        logic [11:0] lim;
        ad = a_t > 14'd1200;
        lim = ad ? 12'd2000 : (charge_level_select ? 12'd450 : 12'd100);
        return {v, v & !sag, v, v & sag, irqn, evi, lim,
                ad ? (charge_level_select ? res : res / 12'd5) : lim};
    endfunction

    task automatic tally_and_finish();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] m, logic [32:0] e);
        if (!w) notes.push_back('{$sformatf("read %h", a), m, e});
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave's answer
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(string n, logic [29:0] m, logic [29:0] e);
        notes.push_back('{n, {3'b000, m}, {3'b000, e}});
        @(posedge core_clk);
        smp <= 1'b1;
        @(posedge core_clk);
        smp <= 1'b0;
    endtask

    task automatic set_in(logic [13:0] s, logic [13:0] a, logic [13:0] r);
        @(posedge core_clk);
        s_t <= s;
        a_t <= a;
        r_t <= r;
        lag <= 4'(xs() % 4);
        repeat (24) @(posedge core_clk);
    endtask

    // Result watcher: each read completion or pin sample consumes the oldest note
    always @(posedge core_clk) begin
        if (((psel && penable && pready && !pwrite) || smp) && notes.size() > 0) begin
            cur = notes.pop_front();
            got = smp ? {3'b000, pv} : {pslverr, prdata};
            cmp_count++;
            if ((got & cur.mask) !== (cur.exp & cur.mask)) begin
                n_errors++;
                $display("wrong value %s expected %h seen %h", cur.name,
                         cur.exp & cur.mask, got & cur.mask);
            end
        end
    end

    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("reset pins", '1, {4'h0, 2'b10, 12'd100, 12'd100});
        apb(0, 12'h000, 0, '1, 0);
        apb(0, 12'h00c, 0, '1, 0);
        apb(0, 12'h018, 0, '1, 33'h1_0000_0000);
        apb(1, 12'h000, 32'h1c, 0, 0);
        apb(0, 12'h000, 0, '1, 33'h1c);
        apb(1, 12'h00c, 32'h1, 0, 0);
        apb(0, 12'h00c, 0, '1, 33'h1);
        set_in(14'd5000, 14'd0, 14'd4200);
        chk("connect", '1, pexp(1, 0, 0, 1));
        apb(0, 12'h004, 0, '1, 33'h161);
        apb(0, 12'h004, 0, '1, 33'h061);
        chk("flag released", M_IRQN, pexp(1, 0, 1, 1));
        apb(1, 12'h008, 32'h1, 0, 0);
        apb(0, 12'h008, 0, 33'h1, 0);
        chk("event cleared", M_EVI, pexp(1, 0, 1, 0));
        for (int i = 0; i < 4; i++) begin
            res <= 12'd5 * (12'd1 + 12'(xs() % 400));
            charge_level_select <= i[0];
            set_in(14'd4000 + 14'(xs() % 2000), i[1] ? 14'd1201 : 14'd1200, 14'd4200);
            pw = pexp(1, 0, 1, 0);
            chk("mode pins", M_PWR, pw);
            apb(0, 12'h010, 0, 33'h0fff_0fff, {5'h0, pw[11:0], 4'h0, pw[23:12]});
            apb(0, 12'h014, 0, 33'h3fff, {19'h0, s_t});
            apb(0, 12'h004, 0, 33'h2, {31'h0, i[1], 1'b0});
        end
        for (int s = 0; s < 4; s++) begin
            apb(1, 12'h000, 32'h1c | 32'(s), 0, 0);
            set_in(ovp_mv[s], a_t, 14'd4200);
            chk("at ovp", M_PWR, pexp(1, 0, 1, 0));
            set_in(ovp_mv[s] + 14'd1, a_t, 14'd4200);
            chk("over ovp", M_PWR, pexp(0, 0, 1, 0));
            apb(0, 12'h004, 0, 33'h1c, 33'h18);
            apb(0, 12'h008, 0, 33'h4, 33'h4);
            set_in(14'd6599, a_t, 14'd4200);
            chk("ovp held", M_PWR, pexp(0, 0, 1, 0));
            apb(0, 12'h004, 0, 33'h18, 33'h10);
            set_in(14'd5999, a_t, 14'd4200);
            chk("ovp resume", M_PWR, pexp(1, 0, 1, 0));
        end
        set_in(14'd3500, a_t, 14'd4200);
        chk("uvlo edge", M_PWR, pexp(1, 0, 1, 0));
        set_in(14'd3499, a_t, 14'd4200);
        chk("uvlo trip", M_PWR, pexp(0, 0, 1, 0));
        apb(0, 12'h004, 0, 33'h5, 33'h4);
        set_in(14'd3999, a_t, 14'd4200);
        chk("uvlo hyst", M_PWR, pexp(0, 0, 1, 0));
        set_in(14'd4000, a_t, 14'd4200);
        chk("uvlo exit", M_PWR, pexp(1, 0, 1, 0));
        for (int k = 0; k < 8; k++) begin
            set_in(14'd3000, a_t, 14'd4200);
            apb(0, 12'h004, 0, 0, 0);
            apb(1, 12'h000, 32'(k) << 2, 0, 0);
            set_in(14'd4000 + 14'(xs() % 2000), a_t, 14'd4200);
            chk("connect irq", M_IRQN, pexp(1, 0, !(k[0] && k[1]), 0));
            apb(0, 12'h004, 0, 0, 0);
            set_in(14'd3000, a_t, 14'd4200);
            chk("disconnect irq", M_IRQN, pexp(0, 0, !(k[0] && k[2]), 0));
        end
        set_in(14'd5000, a_t, 14'd4000);
        chk("rail sag 200", M_PWR, pexp(1, 0, 1, 0));
        set_in(14'd5000, a_t, 14'd3999);
        chk("rail sag 201", M_PWR, pexp(1, 1, 1, 0));
        apb(1, 12'h008, 32'hf, 0, 0);
        apb(1, 12'h00c, 32'h2, 0, 0);
        set_in(14'd3000, a_t, 14'd4200);
        chk("event raised", M_EVI, pexp(0, 0, 1, 1));
        apb(0, 12'h008, 0, 33'hf, 33'ha);
        apb(1, 12'h00c, 32'h0, 0, 0);
        chk("event masked", M_EVI, pexp(0, 0, 1, 0));
        apb(1, 12'h00c, 32'h2, 0, 0);
        apb(1, 12'h008, 32'h2, 0, 0);
        chk("event w1c", M_EVI, pexp(0, 0, 1, 0));
        repeat (4) @(posedge core_clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
